// File: acmc_pkg.sv
// Constants and carrier types for the converter control block
package acmc_pkg;

   // Core clock
   localparam int CLK_NS      = 4;                // 250 MHz period
   // Conversion timing on the internal oscillator
   localparam int CONV_60_MS  = 133;              // 60 Hz notch
   localparam int CONV_50_MS  = 160;              // 50 Hz notch
   localparam int CONV_TICKS  = 20480;            // Osc periods per result
   localparam int OSC_DIV_60  = (CONV_60_MS * 1000000) /
                                (CLK_NS * CONV_TICKS);
   localparam int OSC_DIV_50  = (CONV_50_MS * 1000000) /
                                (CLK_NS * CONV_TICKS);
   localparam int DIV_W       = 11;
   localparam int CNT_W       = 15;
   // External conversion clock detection
   localparam int EXT_MIN_HZ  = 2560;
   localparam int EXT_TIMEOUT = 1000000000 / (EXT_MIN_HZ * CLK_NS);
   // Internal serial clock is the conversion clock divided by 8
   localparam int SCK_DIV     = 8;
   localparam logic [1:0] SCK_HALF_LAST = 2'((SCK_DIV / 2) - 1);
   // Output word
   localparam int WORD_BITS   = 32;
   localparam logic [4:0] LAST_BIT = 5'(WORD_BITS - 1);
   // Filter value in sub-LSB units, full scale is 2^28
   localparam int VAL_W = 30;
   localparam logic signed [VAL_W-1:0] FULL_SCALE = 30'sh1000_0000;
   localparam logic signed [VAL_W-1:0] CLAMP_HI   = 30'sh11ff_ffff;
   localparam logic signed [VAL_W-1:0] CLAMP_LO   = 30'sh3e00_0000;

   typedef enum logic [1:0] {
      ACMC_CONVERT = 2'b00,
      ACMC_SLEEP   = 2'b01,
      ACMC_DATA    = 2'b10
   } acmc_state_t;

   // Output word, first bit sent is eoc
   typedef struct packed {
      logic        eoc;
      logic        dummy_bit;
      logic        sign_flag;
      logic        range_exceeded_flag;
      logic [23:0] result;
      logic [3:0]  sub_lsb;
   } acmc_word_t;

   // Multiplexer setting
   typedef struct packed {
      logic       enable;
      logic [2:0] code;
   } acmc_chan_t;

   // Serial pins from the host
   typedef struct packed {
      logic converter_select_n;
      logic channel_select_n;
      logic sck;
      logic mux_clk;
      logic din;
   } acmc_serial_in_t;

endpackage : acmc_pkg

// File: acmc_edge.sv
// Edge detector for one synchronous input
`timescale 1ns/1ps
module acmc_edge #(
   parameter logic RST = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_d,
   output logic      o_rise,
   output logic      o_fall
);

   typedef struct packed {
      logic prev;
   } acmc_edge_st_t;

   acmc_edge_st_t q;
   acmc_edge_st_t d;

   // Next state
   always_comb begin
      d      = q;
      d.prev = i_d;
   end

   // State register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q.prev <= RST;
      end else begin
         q <= d;
      end
   end

   assign o_rise = i_d & ~q.prev;
   assign o_fall = ~i_d & q.prev;

endmodule : acmc_edge

// File: acmc_clk_det.sv
// Detector for a running clock on the rejection select pin
`timescale 1ns/1ps
module acmc_clk_det #(
   parameter int TIMEOUT = acmc_pkg::EXT_TIMEOUT
) (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_rise,
   output logic      o_present
);

   localparam int W = $clog2(TIMEOUT + 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         seen;
      logic         present;
   } acmc_det_st_t;

   acmc_det_st_t q;
   acmc_det_st_t d;

   // Two rising edges within the timeout mean a clock is there
   always_comb begin
      d = q;
      if (i_rise) begin
         d.present = q.seen;
         d.seen    = 1'b1;
         d.cnt     = '0;
      end else if (q.cnt == W'(TIMEOUT)) begin
         d.present = 1'b0;
         d.seen    = 1'b0;
      end else begin
         d.cnt = q.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_present = q.present;

endmodule : acmc_clk_det

// File: acmc_top.sv
// Channel, conversion timing and output word control of the converter
//
// Functional notes
// - Channel bits sampled on mux clock rise
// - Enable bit then three-bit channel code
// - New channel drives output after select falls
// - Sleep while programming, convert after read
// - Word: eoc, dummy, sign, range, result, sub
// - Sign high positive; negatives count down
// - Four sub-LSBs carry valid extra data
// - Low pin selects 60 Hz, high 50 Hz
// - Rejection change spoils only current conversion
// - Detect external clock, stop internal oscillator
// - External notch at clock over 2560
// - No external clock restarts internal oscillator
// - Clock source change spoils only conversion
// - Conversion lasts 20480 oscillator periods
// - Sleep until select low and clock rise
// - Internal serial clock: at most 32 cycles
// - Eoc high converting, low when done
// - Range flag set outside zero to reference
// - Results clamped at nine and minus eighths
`timescale 1ns/1ps
module acmc_top #(
   parameter int CONV_TICKS  = acmc_pkg::CONV_TICKS,
   parameter int EXT_TIMEOUT = acmc_pkg::EXT_TIMEOUT
) (
   input  wire logic                                i_clk,
   input  wire logic                                i_reset_n,
   input  wire acmc_pkg::acmc_serial_in_t           i_serial,
   input  wire logic                                i_rejection_select_pin,
   input  wire logic signed [acmc_pkg::VAL_W-1:0]   i_conv_value,
   output logic                                     o_sdo,
   output logic                                     o_sdo_oe,
   output logic                                     o_sck,
   output logic                                     o_sck_oe,
   output acmc_pkg::acmc_chan_t                     o_channel,
   output logic                                     o_conv_start,
   output logic                                     o_ext_clock,
   output logic                                     o_int_sck_mode
);

   typedef struct packed {
      acmc_pkg::acmc_state_t              state;
      logic [acmc_pkg::DIV_W-1:0]         div;
      logic [acmc_pkg::CNT_W-1:0]         conv_cnt;
      logic [4:0]                         bit_cnt;
      acmc_pkg::acmc_word_t               word;
      acmc_pkg::acmc_chan_t               chan_sr;
      acmc_pkg::acmc_chan_t               chan;
      logic                               int_sck;
      logic                               mode_ok;
      logic                               gen_sck;
      logic [1:0]                         gen_cnt;
      logic                               sdo;
      logic                               sdo_oe;
      logic                               sck_oe;
      logic                               conv_start;
   } acmc_top_st_t;

   acmc_top_st_t q;
   acmc_top_st_t n;

   logic                       cs_rise;
   logic                       cs_fall;
   logic                       chsel_fall;
   logic                       mux_rise;
   logic                       f0_rise;
   logic                       sck_now;
   logic                       sck_rise;
   logic                       sck_fall;
   logic                       ext_present;
   logic                       int_tick;
   logic                       conv_tick;
   logic                       start;
   logic [acmc_pkg::DIV_W-1:0] div_top;

   // Filter value to output word, with clamping and flags
   function automatic acmc_pkg::acmc_word_t fmt(
      input logic signed [acmc_pkg::VAL_W-1:0] val);
      acmc_pkg::acmc_word_t              w;
      logic signed [acmc_pkg::VAL_W-1:0] v;
      v = val;
      if (v > acmc_pkg::CLAMP_HI) begin
         v = acmc_pkg::CLAMP_HI;
      end else if (v < acmc_pkg::CLAMP_LO) begin
         v = acmc_pkg::CLAMP_LO;
      end
      w.eoc                 = 1'b0;
      w.dummy_bit           = 1'b0;
      w.sign_flag           = ~v[acmc_pkg::VAL_W-1];
      w.range_exceeded_flag = v[acmc_pkg::VAL_W-1] |
                              (v >= acmc_pkg::FULL_SCALE);
      {w.result, w.sub_lsb} = v[27:0];
      return w;
   endfunction : fmt

   // Edge detectors on the host pins and on the shifter serial clock
   acmc_edge #(.RST(1'b1)) u_cs_edge (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       (i_serial.converter_select_n),
      .o_rise    (cs_rise),
      .o_fall    (cs_fall)
   );

   acmc_edge #(.RST(1'b1)) u_chsel_edge (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       (i_serial.channel_select_n),
      .o_rise    (),
      .o_fall    (chsel_fall)
   );

   acmc_edge #(.RST(1'b0)) u_mux_edge (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       (i_serial.mux_clk),
      .o_rise    (mux_rise),
      .o_fall    ()
   );

   acmc_edge #(.RST(1'b0)) u_f0_edge (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       (i_rejection_select_pin),
      .o_rise    (f0_rise),
      .o_fall    ()
   );

   acmc_edge #(.RST(1'b0)) u_sck_edge (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_d       (sck_now),
      .o_rise    (sck_rise),
      .o_fall    (sck_fall)
   );

   // External conversion clock presence
   acmc_clk_det #(.TIMEOUT(EXT_TIMEOUT)) u_clk_det (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_rise    (f0_rise),
      .o_present (ext_present)
   );

   // Serial clock seen by the output shifter
   assign sck_now = q.int_sck ? q.gen_sck : i_serial.sck;

   // Next state
   always_comb begin
      n            = q;
      n.conv_start = 1'b0;
      int_tick     = 1'b0;
      start        = 1'b0;
      // Internal oscillator, off while an external clock runs
      div_top = i_rejection_select_pin ?
                acmc_pkg::DIV_W'(acmc_pkg::OSC_DIV_50 - 1) :
                acmc_pkg::DIV_W'(acmc_pkg::OSC_DIV_60 - 1);
      if (ext_present) begin
         n.div = '0;
      end else if (q.div >= div_top) begin
         n.div    = '0;
         int_tick = 1'b1;
      end else begin
         n.div = q.div + 1'b1;
      end
      // A source or notch change only changes the tick rate of the running count
      conv_tick = ext_present ? f0_rise : int_tick;

      // Serial clock mode taken after reset and at each select fall
      if (!q.mode_ok || cs_fall) begin
         n.int_sck = i_serial.sck;
         n.mode_ok = 1'b1;
      end

      // Internal serial clock, conversion clock over 8
      if (!q.int_sck || i_serial.converter_select_n ||
          q.state == acmc_pkg::ACMC_CONVERT) begin
         n.gen_sck = 1'b0;
         n.gen_cnt = '0;
      end else if (conv_tick) begin
         n.gen_cnt = q.gen_cnt + 1'b1;
         if (q.gen_cnt == acmc_pkg::SCK_HALF_LAST) begin
            n.gen_cnt = '0;
            n.gen_sck = ~q.gen_sck;
         end
      end

      // Channel word shifted in while the mux select is high
      if (i_serial.channel_select_n && mux_rise) begin
         n.chan_sr = acmc_pkg::acmc_chan_t'(
                     {q.chan_sr[2:0], i_serial.din});
      end
      // Setting takes effect on the select falling edge
      if (chsel_fall) begin
         n.chan = q.chan_sr;
      end

      // Converter state machine
      unique case (q.state)
         acmc_pkg::ACMC_CONVERT: begin
            if (conv_tick) begin
               if (q.conv_cnt ==
                   acmc_pkg::CNT_W'(CONV_TICKS - 1)) begin
                  n.state = acmc_pkg::ACMC_SLEEP;
                  n.word  = fmt(i_conv_value);
               end else begin
                  n.conv_cnt = q.conv_cnt + 1'b1;
               end
            end
         end
         acmc_pkg::ACMC_SLEEP: begin
            // Held here while selected high; mux may be programmed
            if (!i_serial.converter_select_n && sck_rise) begin
               n.state   = acmc_pkg::ACMC_DATA;
               n.bit_cnt = '0;
            end
         end
         acmc_pkg::ACMC_DATA: begin
            if (cs_rise) begin
               start = 1'b1;
            end else if (sck_fall) begin
               if (q.bit_cnt == acmc_pkg::LAST_BIT) begin
                  start = 1'b1;
               end else begin
                  n.word = acmc_pkg::acmc_word_t'(
                           {q.word[30:0], 1'b0});
                  n.bit_cnt = q.bit_cnt + 1'b1;
               end
            end
         end
         default: begin
            n.state = acmc_pkg::ACMC_CONVERT;
         end
      endcase

      // New conversion on the newly selected channel
      if (start) begin
         n.state      = acmc_pkg::ACMC_CONVERT;
         n.conv_cnt   = '0;
         n.conv_start = 1'b1;
      end

      // Output pins follow the next state
      n.sdo_oe = ~i_serial.converter_select_n;
      n.sdo    = (n.state == acmc_pkg::ACMC_CONVERT) ? 1'b1 :
                 n.word[31];
      n.sck_oe = n.int_sck & ~i_serial.converter_select_n;
   end

   // State register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         q       <= '0;
         q.state <= acmc_pkg::ACMC_CONVERT;
         q.sdo   <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from flops
   assign o_sdo          = q.sdo;
   assign o_sdo_oe       = q.sdo_oe;
   assign o_sck          = q.gen_sck;
   assign o_sck_oe       = q.sck_oe;
   assign o_channel      = q.chan;
   assign o_conv_start   = q.conv_start;
   assign o_ext_clock    = ext_present;
   assign o_int_sck_mode = q.int_sck;

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_eoc_while_conv: assert property (
      q.state == acmc_pkg::ACMC_CONVERT && o_sdo_oe |-> o_sdo)
      else $error("eoc low during conversion");

   a_sdo_off_desel: assert property (
      i_serial.converter_select_n |=> !o_sdo_oe)
      else $error("sdo driven while deselected");

   a_conv_length: assert property (
      q.state == acmc_pkg::ACMC_CONVERT ##1
      q.state == acmc_pkg::ACMC_SLEEP |->
      $past(q.conv_cnt) == acmc_pkg::CNT_W'(CONV_TICKS - 1))
      else $error("conversion ended at wrong count");

   a_sleep_hold: assert property (
      q.state == acmc_pkg::ACMC_SLEEP &&
      i_serial.converter_select_n |=> q.state == acmc_pkg::ACMC_SLEEP)
      else $error("left sleep while deselected");

   a_word_ends: assert property (
      q.state == acmc_pkg::ACMC_DATA && sck_fall && !cs_rise &&
      q.bit_cnt == acmc_pkg::LAST_BIT |=>
      q.state == acmc_pkg::ACMC_CONVERT && o_conv_start ##1 !o_conv_start)
      else $error("word not ended after 32 clocks");

   a_abort_read: assert property (
      q.state == acmc_pkg::ACMC_DATA && cs_rise |=>
      q.state == acmc_pkg::ACMC_CONVERT && q.conv_cnt == '0)
      else $error("read not aborted by select rise");

   a_chan_apply: assert property (
      chsel_fall |=> o_channel == $past(q.chan_sr))
      else $error("channel not applied on select fall");

   a_chan_hold: assert property (
      !chsel_fall |=> $stable(o_channel))
      else $error("channel changed without select fall");

   a_bit_shift: assert property (
      i_serial.channel_select_n && mux_rise |=>
      q.chan_sr[0] == $past(i_serial.din) &&
      q.chan_sr[3:1] == $past(q.chan_sr[2:0]))
      else $error("channel bit not shifted in");

   a_word_status: assert property (
      q.state == acmc_pkg::ACMC_CONVERT ##1
      q.state == acmc_pkg::ACMC_SLEEP |->
      !q.word.eoc && !q.word.dummy_bit &&
      (q.word.sign_flag || q.word.range_exceeded_flag))
      else $error("bad status bits in new word");

   a_osc_off_ext: assert property (
      ext_present |-> !int_tick ##1 q.div == '0)
      else $error("internal oscillator runs with external clock");

   c_full_read: cover property (
      q.state == acmc_pkg::ACMC_DATA && sck_fall &&
      q.bit_cnt == acmc_pkg::LAST_BIT);
   c_abort: cover property (
      q.state == acmc_pkg::ACMC_DATA && cs_rise);
   c_ext_clock: cover property ($rose(ext_present));
   c_int_sck_read: cover property (
      q.int_sck && q.state == acmc_pkg::ACMC_DATA);

endmodule : acmc_top

// File: acmc_host_model.sv
// Host model driving the converter serial pins and rejection pin
`timescale 1ns/1ps
module acmc_host_model (
   input  wire logic                 i_clk,
   input  wire logic                 i_sdo,
   output acmc_pkg::acmc_serial_in_t o_serial,
   output logic                      o_rej_pin
);
   logic ext_on;
   logic rej_level;
   logic ext_lvl;
   logic sel_n;
   logic clk_lvl;
   logic din;
   int   ext_cnt;

   // Idle: selects high, shared clocks low, data low
   initial begin
      sel_n     = 1'b1;
      clk_lvl   = 1'b0;
      din       = 1'b0;
      ext_on    = 1'b0;
      ext_lvl   = 1'b0;
      rej_level = 1'b0;
      ext_cnt   = 0;
   end

   // One select and one clock feed both pin pairs
   assign o_serial  = {sel_n, sel_n, clk_lvl, clk_lvl, din};
   // Fixed notch level, or a free clock of 20 core cycles
   assign o_rej_pin = ext_on ? ext_lvl : rej_level;

   // External conversion clock, toggled every 10 core cycles
   always @(posedge i_clk) begin
      #1;
      ext_cnt = (ext_cnt + 1) % 10;
      if (ext_cnt == 0) begin
         ext_lvl = ~ext_lvl;
      end
   end

   // Changes land just after an edge
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wait_cyc

   // One clock source feeds both serial clocks
   task automatic set_clk(input logic lvl);
      clk_lvl = lvl;
   endtask : set_clk

   // Both selects tied together
   task automatic select(input logic lvl);
      sel_n = lvl;
      wait_cyc(2);
   endtask : select

   // Enable bit first, then code MSB first, data set before the rise
   task automatic shift_word(input logic [3:0] w);
      for (int i = 3; i >= 0; i--) begin
         din = w[i];
         wait_cyc(2);
         set_clk(1'b1);
         wait_cyc(2);
         set_clk(1'b0);
      end
      wait_cyc(2);
   endtask : shift_word

   // Clocks out at most 32 bits, each taken after the rise
   task automatic read_word(input int nbits, output logic [31:0] w);
      w = 32'h0;
      for (int i = 0; i < nbits; i++) begin
         set_clk(1'b1);
         wait_cyc(3);
         w = {w[30:0], i_sdo};
         set_clk(1'b0);
         wait_cyc(3);
      end
   endtask : read_word
endmodule : acmc_host_model

// File: tb_adc_mux_channel_and_output_control.sv
// Self-checking bench for the converter channel and output control
`timescale 1ns/1ps
module tb_adc_mux_channel_and_output_control;
   localparam int TICKS = 8;
   localparam int DIV60 = acmc_pkg::OSC_DIV_60;
   localparam int DIV50 = acmc_pkg::OSC_DIV_50;
   logic                              clk = 1'b0;
   logic                              reset_n = 1'b0;
   acmc_pkg::acmc_serial_in_t         serial;
   logic                              rej_pin;
   logic signed [acmc_pkg::VAL_W-1:0] conv_value;
   logic                              sdo;
   logic                              sdo_oe;
   logic                              sck;
   logic                              sck_oe;
   acmc_pkg::acmc_chan_t              channel;
   logic                              conv_start;
   logic                              ext_clock;
   logic                              int_sck;
   logic [3:0]                        nxt;
   logic [3:0]                        prev = 4'h0;
   logic [31:0]                       word;
   logic signed [29:0]                vals [6];
   int err_total = 0;
   int cmp_count = 0;
   int seed = 81;
   int starts = 0;
   int cyc = 0;
   int t_start = 0;
   int el;

   acmc_top #(.CONV_TICKS(TICKS), .EXT_TIMEOUT(50)) uut (
      .i_clk(clk), .i_reset_n(reset_n), .i_serial(serial),
      .i_rejection_select_pin(rej_pin), .i_conv_value(conv_value),
      .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_sck(sck), .o_sck_oe(sck_oe),
      .o_channel(channel), .o_conv_start(conv_start),
      .o_ext_clock(ext_clock), .o_int_sck_mode(int_sck));

   acmc_host_model host (
      .i_clk(clk), .i_sdo(sdo), .o_serial(serial), .o_rej_pin(rej_pin));

   // 250 MHz clock
   always #2 clk = ~clk;

   // Cycle count and conversion start pulses
   always @(posedge clk) begin
      cyc++;
      if (conv_start === 1'b1) begin
         starts++;
         t_start = cyc;
      end
   end

   // Compares and counts one value
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Expected word: clamp, sign, range, low 28 bits
   function automatic logic [31:0] exp_word(input logic signed [29:0] v);
      logic signed [29:0] c;
      c = v;
      if (v > acmc_pkg::CLAMP_HI) c = acmc_pkg::CLAMP_HI;
      if (v < acmc_pkg::CLAMP_LO) c = acmc_pkg::CLAMP_LO;
      return {2'h0, c >= 0, (c < 0) || (c >= acmc_pkg::FULL_SCALE), c[27:0]};
   endfunction : exp_word

   // Select low, wait for end of conversion, check its length
   task automatic wait_eoc(input int exp, input int tol);
      int n;
      n = 0;
      host.select(1'b0);
      check(sdo_oe, 1'b1);
      check(sdo, 1'b1);
      while (sdo !== 1'b0 && n < exp + 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      el = cyc - t_start;
      check(el >= exp - tol && el <= exp + 8, 1'b1);
   endtask : wait_eoc

   // Reads nbits, queues the next value, checks the new start
   task automatic read_check(input logic signed [29:0] nv, input int nbits);
      logic [31:0] exp;
      int s0;
      exp = exp_word(conv_value);
      conv_value = nv;
      s0 = starts;
      host.read_word(nbits, word);
      check(word, exp >> (32 - nbits));
      if (nbits == 32) check(sdo, 1'b1);
      host.select(1'b1);
      check(starts - s0, 1);
   endtask : read_check

   // Cuts a hang short well past the expected 40k cycles
   initial begin
      #(60000 * acmc_pkg::CLK_NS);
      err_total++;
      finish_test();
   end

   // Main sequence
   initial begin
      conv_value = 30'($random(seed));
      vals = '{30'sh0, -30'sh1, acmc_pkg::FULL_SCALE,
               acmc_pkg::FULL_SCALE - 30'sh1, 30'sh1fff_ffff, 30'sh2000_0000};
      repeat (3) @(posedge clk);
      #1;
      reset_n = 1'b1;
      t_start = cyc;
      check({28'h0, channel}, 32'h0);
      check(int_sck, 1'b0);
      wait_eoc(TICKS * DIV60, DIV60);
      // Every code while asleep, then a word with enable low
      for (int c = 0; c < 9; c++) begin
         nxt = (c < 8) ? {1'b1, 3'(c)} : {1'b0, 3'($random(seed))};
         host.select(1'b1);
         host.shift_word(nxt);
         check({28'h0, channel}, {28'h0, prev});
         host.select(1'b0);
         if (c < 8) begin
            check({28'h0, channel}, {28'h0, nxt});
         end else begin
            check({31'h0, channel.enable}, 32'h0);
         end
         prev = nxt;
      end
      host.rej_level = 1'b1;
      read_check(30'($random(seed)), 32);
      wait_eoc(TICKS * DIV50, DIV50);
      // External conversion clock switched on in sleep
      host.ext_on = 1'b1;
      for (int i = 0; i < 200 && ext_clock !== 1'b1; i++) host.wait_cyc(1);
      check(ext_clock, 1'b1);
      read_check(vals[0], 32);
      for (int i = 0; i < 12; i++) begin
         wait_eoc(TICKS * 20, 20);
         read_check(i < 5 ? vals[i + 1] : 30'($random(seed)),
                    i == 11 ? 9 : 32);
      end
      host.ext_on = 1'b0;
      for (int i = 0; i < 200 && ext_clock !== 1'b0; i++) host.wait_cyc(1);
      check(ext_clock, 1'b0);
      // Second reset with the serial clock high
      reset_n = 1'b0;
      host.set_clk(1'b1);
      host.wait_cyc(3);
      reset_n = 1'b1;
      host.wait_cyc(3);
      check(int_sck, 1'b1);
      check(sck_oe, 1'b0);
      host.select(1'b0);
      host.wait_cyc(1);
      check(sck_oe, 1'b1);
      // Internal serial clock read on the external conversion clock
      conv_value = 30'($random(seed));
      host.ext_on = 1'b1;
      el = starts;
      for (int i = 0; i < 32; i++) begin
         @(posedge sck);
         #1;
         word = {word[30:0], sdo};
      end
      host.wait_cyc(90);
      check(word, exp_word(conv_value));
      check(starts - el, 1);
      check(sck, 1'b0);
      finish_test();
   end

   // Prints the counts and the verdict, then ends the run
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
endmodule : tb_adc_mux_channel_and_output_control
